// ---- core/error_status_reporting.sv ----
// Error and status registers behind the host serial port
`timescale 1ns/1ns
`default_nettype none
module error_status_reporting
  import err_report_pkg::*;
#(
  parameter logic [6:0] host_address = default_host_address
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host serial port, open drain data
  input wire logic host_scl,
  input wire logic host_sda_in,
  output logic host_sda_out_q,
  output logic host_sda_oe_n_q,
  // Fault and state sources from the core
  input wire hw_fault_type hw_fault,
  input wire sw_fault_type sw_fault,
  input wire logic processor_reset_done,
  input wire logic core_idle,
  input wire logic [result_count-1:0] result_ready,
  // Control toward the core and host
  output logic standby_q,
  output logic sensor_power_down_q,
  output logic host_irq_q,
  output logic reset_request_q
);

  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_addr = 9'h002,
    st_addr_ack = 9'h004,
    st_reg = 9'h008,
    st_reg_ack = 9'h010,
    st_wdata = 9'h020,
    st_wdata_ack = 9'h040,
    st_rdata = 9'h080,
    st_rdata_ack = 9'h100
  } port_state_type;

  logic scl_q;
  logic sda_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  port_state_type state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic read_mode_q;
  logic master_ack_q;
  logic wr_strobe;
  logic rd_load;
  logic [7:0] rd_data;
  logic hw_fault_any;
  logic [7:0] event_flags_q;
  logic [7:0] sensor_fault_flags_q;
  logic eeprom_fail_q;
  logic idle_q;
  logic [7:0] error_code_q;
  logic [7:0] error_code_d;
  logic [7:0] mag_sample_rate_q;
  logic [7:0] accel_sample_rate_q;
  logic [7:0] gyro_sample_rate_q;
  logic reset_cmd;

  pin_sync #(.reset_level(1'b1)) scl_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(host_scl),
    .level_q(scl_q)
  );

  pin_sync #(.reset_level(1'b1)) sda_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(host_sda_in),
    .level_q(sda_q)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_prev_q;
  assign scl_fall = !scl_q && scl_prev_q;
  assign start_seen = scl_q && scl_prev_q && sda_prev_q && !sda_q;
  assign stop_seen = scl_q && scl_prev_q && !sda_prev_q && sda_q;

  // Write strobe at the SCL fall after the eighth data bit, as the acknowledge starts; read load at start of each byte
  assign wr_strobe = scl_fall && (state_q == st_wdata) && (bit_cnt_q == bits_per_byte);
  assign rd_load = scl_fall && (((state_q == st_addr_ack) && read_mode_q) ||
                                ((state_q == st_rdata_ack) && master_ack_q));
  assign reset_cmd = wr_strobe && (ptr_q == reset_request_addr) && (shift_q == reset_request_cmd);

  // Host port bit engine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= st_idle;
      bit_cnt_q <= 4'h0;
      shift_q <= zero_byte;
      tx_q <= zero_byte;
      read_mode_q <= 1'b0;
      master_ack_q <= 1'b0;
      host_sda_oe_n_q <= 1'b1;
    end else if (start_seen) begin
      state_q <= st_addr;
      bit_cnt_q <= 4'h0;
      host_sda_oe_n_q <= 1'b1;
    end else if (stop_seen) begin
      state_q <= st_idle;
      host_sda_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        st_addr, st_reg, st_wdata: begin
          if (scl_rise && bit_cnt_q != bits_per_byte) begin
            shift_q <= {shift_q[6:0], sda_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == bits_per_byte) begin
            bit_cnt_q <= 4'h0;
            if (state_q == st_addr) begin
              if (shift_q[7:1] == host_address) begin
                read_mode_q <= shift_q[0];
                host_sda_oe_n_q <= 1'b0;
                state_q <= st_addr_ack;
              end else begin
                state_q <= st_idle;
              end
            end else begin
              host_sda_oe_n_q <= 1'b0;
              state_q <= (state_q == st_reg) ? st_reg_ack : st_wdata_ack;
            end
          end
        end
        st_addr_ack, st_reg_ack, st_wdata_ack: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (state_q == st_addr_ack && read_mode_q) begin
              tx_q <= rd_data;
              host_sda_oe_n_q <= rd_data[7];
              state_q <= st_rdata;
            end else begin
              host_sda_oe_n_q <= 1'b1;
              state_q <= (state_q == st_addr_ack) ? st_reg : st_wdata;
            end
          end
        end
        st_rdata: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == bits_per_byte) begin
              host_sda_oe_n_q <= 1'b1;
              state_q <= st_rdata_ack;
            end else begin
              host_sda_oe_n_q <= tx_q[3'(7 - bit_cnt_q)];
            end
          end
        end
        st_rdata_ack: begin
          if (scl_rise) begin
            master_ack_q <= !sda_q;
          end else if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (master_ack_q) begin
              tx_q <= rd_data;
              host_sda_oe_n_q <= rd_data[7];
              state_q <= st_rdata;
            end else begin
              state_q <= st_idle;
            end
          end
        end
        default: begin
          state_q <= st_idle;
          host_sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // Data line only ever pulled low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_sda_out_q <= 1'b0;
    end else begin
      host_sda_out_q <= 1'b0;
    end
  end

  // Register pointer, set by the second byte, stepping after each written byte and as each read byte is loaded
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_q <= zero_byte;
    end else if (scl_fall && state_q == st_reg && bit_cnt_q == bits_per_byte) begin
      ptr_q <= shift_q;
    end else if (wr_strobe || rd_load) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Read data selection
  always_comb begin
    if (ptr_q == event_flags_addr) begin
      rd_data = event_flags_q;
    end else if (ptr_q == sensor_fault_flags_addr) begin
      rd_data = sensor_fault_flags_q;
    end else if (ptr_q == core_status_addr) begin
      rd_data = zero_byte;
      rd_data[status_eeprom_fail_bit] = eeprom_fail_q;
      rd_data[status_idle_bit] = idle_q;
    end else if (ptr_q == error_code_addr) begin
      rd_data = error_code_q;
    end else if (ptr_q == mag_sample_rate_addr) begin
      rd_data = mag_sample_rate_q;
    end else if (ptr_q == accel_sample_rate_addr) begin
      rd_data = accel_sample_rate_q;
    end else if (ptr_q == gyro_sample_rate_addr) begin
      rd_data = gyro_sample_rate_q;
    end else begin
      rd_data = zero_byte;
    end
  end

  assign hw_fault_any = hw_fault.eeprom_load_fail || hw_fault.power_transient || hw_fault.watchdog_fault;

  // Event flags: new events win over the read clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_flags_q <= zero_byte;
    end else begin
      event_flags_q <= (rd_load && ptr_q == event_flags_addr) ? zero_byte : event_flags_q;
      if (processor_reset_done || reset_cmd) begin
        event_flags_q[event_proc_reset_bit] <= 1'b1;
      end
      if (hw_fault_any || error_code_d != code_none || |sw_fault.no_ack || |sw_fault.identity_mismatch) begin
        event_flags_q[event_error_bit] <= 1'b1;
      end
      for (int i = 0; i < result_count; i++) begin
        if (result_ready[i]) begin
          event_flags_q[event_result_lsb + i] <= 1'b1;
        end
      end
    end
  end

  // Sensor fault flags, sticky until a reset request; a same-cycle fault wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sensor_fault_flags_q <= zero_byte;
    end else begin
      if (reset_cmd) begin
        sensor_fault_flags_q <= zero_byte;
      end
      for (int i = 0; i < sensor_count; i++) begin
        if (sw_fault.no_ack[i]) begin
          sensor_fault_flags_q[nack_lsb + i] <= 1'b1;
        end
        if (sw_fault.identity_mismatch[i]) begin
          sensor_fault_flags_q[identity_lsb + i] <= 1'b1;
        end
      end
    end
  end

  // Core status bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eeprom_fail_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      idle_q <= core_idle;
      if (hw_fault.eeprom_load_fail) begin
        eeprom_fail_q <= 1'b1;
      end else if (reset_cmd) begin
        eeprom_fail_q <= 1'b0;
      end
    end
  end

  // Error code priority: rate, math, initialisation, then rate failure
  always_comb begin
    error_code_d = code_none;
    if (sw_fault.bad_rate) begin
      error_code_d = code_bad_rate;
    end else if (sw_fault.math_error) begin
      error_code_d = code_math;
    end else if (sw_fault.init_fail[0]) begin
      error_code_d = code_mag_init;
    end else if (sw_fault.init_fail[1]) begin
      error_code_d = code_accel_init;
    end else if (sw_fault.init_fail[2]) begin
      error_code_d = code_gyro_init;
    end else if (sw_fault.rate_fail[0]) begin
      error_code_d = code_mag_rate;
    end else if (sw_fault.rate_fail[1]) begin
      error_code_d = code_accel_rate;
    end else if (sw_fault.rate_fail[2]) begin
      error_code_d = code_gyro_rate;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      error_code_q <= code_none;
    end else if (error_code_d != code_none) begin
      error_code_q <= error_code_d;
    end else if (reset_cmd) begin
      error_code_q <= code_none;
    end
  end

  // Sample rates: host writable, lost on a hardware fault
  always_ff @(posedge ref_clk) begin
    if (rst || hw_fault_any) begin
      mag_sample_rate_q <= zero_byte;
      accel_sample_rate_q <= zero_byte;
      gyro_sample_rate_q <= zero_byte;
    end else if (wr_strobe) begin
      if (ptr_q == mag_sample_rate_addr) begin
        mag_sample_rate_q <= shift_q;
      end else if (ptr_q == accel_sample_rate_addr) begin
        accel_sample_rate_q <= shift_q;
      end else if (ptr_q == gyro_sample_rate_addr) begin
        gyro_sample_rate_q <= shift_q;
      end
    end
  end

  // Standby and sensor shutdown on hardware fault, left by reset request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      standby_q <= 1'b0;
      sensor_power_down_q <= 1'b0;
      reset_request_q <= 1'b0;
    end else begin
      reset_request_q <= reset_cmd;
      if (hw_fault_any) begin
        standby_q <= 1'b1;
        sensor_power_down_q <= 1'b1;
      end else if (reset_cmd) begin
        standby_q <= 1'b0;
        sensor_power_down_q <= 1'b0;
      end
    end
  end

  // Interrupt while any event flag is pending
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_irq_q <= 1'b0;
    end else begin
      host_irq_q <= |event_flags_q;
    end
  end

endmodule : error_status_reporting
`default_nettype wire

// ---- core/err_report_pkg.sv ----
// Register map, field positions and event carriers for the error reporting block
package err_report_pkg;

  // Register offsets on the host port
  localparam logic [7:0] event_flags_addr = 8'h35;
  localparam logic [7:0] sensor_fault_flags_addr = 8'h36;
  localparam logic [7:0] core_status_addr = 8'h37;
  localparam logic [7:0] error_code_addr = 8'h50;
  localparam logic [7:0] mag_sample_rate_addr = 8'h55;
  localparam logic [7:0] accel_sample_rate_addr = 8'h56;
  localparam logic [7:0] gyro_sample_rate_addr = 8'h57;
  localparam logic [7:0] reset_request_addr = 8'h9B;

  // Field positions
  localparam int event_proc_reset_bit = 0;
  localparam int event_error_bit = 1;
  localparam int event_result_lsb = 2;
  localparam int result_count = 4;
  localparam int status_eeprom_fail_bit = 2;
  localparam int status_idle_bit = 3;
  localparam int nack_lsb = 0;
  localparam int identity_lsb = 4;
  localparam int sensor_count = 3;

  // Values
  localparam logic [7:0] zero_byte = 8'h00;
  localparam logic [7:0] reset_request_cmd = 8'h01;
  localparam logic [7:0] code_none = 8'h00;
  localparam logic [7:0] code_bad_rate = 8'h80;
  localparam logic [7:0] code_math = 8'h30;
  localparam logic [7:0] code_mag_init = 8'h21;
  localparam logic [7:0] code_accel_init = 8'h22;
  localparam logic [7:0] code_gyro_init = 8'h24;
  localparam logic [7:0] code_mag_rate = 8'h11;
  localparam logic [7:0] code_accel_rate = 8'h12;
  localparam logic [7:0] code_gyro_rate = 8'h14;

  // Host port framing
  localparam logic [6:0] default_host_address = 7'h28;
  localparam logic [3:0] bits_per_byte = 4'h8;

  // Hardware fault sources, one-cycle pulses
  typedef struct packed {
    logic eeprom_load_fail;
    logic power_transient;
    logic watchdog_fault;
  } hw_fault_type;

  // Software fault sources; vectors ordered gyro, accel, mag (bit 0 = mag)
  typedef struct packed {
    logic [sensor_count-1:0] no_ack;
    logic [sensor_count-1:0] identity_mismatch;
    logic [sensor_count-1:0] init_fail;
    logic [sensor_count-1:0] rate_fail;
    logic bad_rate;
    logic math_error;
  } sw_fault_type;

endpackage : err_report_pkg

// ---- core/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import err_report_pkg::*;
#(
  parameter logic reset_level = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pin and filtered level
  input wire logic pin,
  output logic level_q
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1_q <= reset_level;
      stage2_q <= reset_level;
      stage3_q <= reset_level;
    end else begin
      stage1_q <= pin;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= reset_level;
    end else if (stage2_q == stage3_q) begin
      level_q <= stage3_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ---- tb/error_status_reporting_monitor.sv ----
// Concurrent checks on the ports of the error reporting block
`timescale 1ns/1ns
`default_nettype none
module error_status_reporting_monitor
  import err_report_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host port
  input wire logic host_scl,
  input wire logic host_sda_in,
  input wire logic host_sda_out_q,
  input wire logic host_sda_oe_n_q,
  // Fault and state sources
  input wire hw_fault_type hw_fault,
  input wire sw_fault_type sw_fault,
  input wire logic processor_reset_done,
  input wire logic core_idle,
  input wire logic [result_count-1:0] result_ready,
  // Control outputs
  input wire logic standby_q,
  input wire logic sensor_power_down_q,
  input wire logic host_irq_q,
  input wire logic reset_request_q
);
  logic cause;
  assign cause = processor_reset_done | (|hw_fault) | (|sw_fault) | (|result_ready);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_hw_standby;
    |hw_fault |=> standby_q && sensor_power_down_q;
  endproperty
  a_hw_standby: assert property (p_hw_standby) else $error("no standby after hw fault");
  property p_pd_same;
    sensor_power_down_q == standby_q;
  endproperty
  a_pd_same: assert property (p_pd_same) else $error("power down differs from standby");
  property p_hw_irq;
    |hw_fault |-> ##2 host_irq_q;
  endproperty
  a_hw_irq: assert property (p_hw_irq) else $error("no interrupt after hw fault");
  property p_proc_irq;
    processor_reset_done |-> ##2 host_irq_q;
  endproperty
  a_proc_irq: assert property (p_proc_irq) else $error("no interrupt after processor reset");
  property p_sw_irq;
    |sw_fault |-> ##2 host_irq_q;
  endproperty
  a_sw_irq: assert property (p_sw_irq) else $error("no interrupt after sw error");
  property p_irq_cause;
    $rose(host_irq_q) |-> $past(cause, 2) || $past(reset_request_q, 1) || $past(reset_request_q, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
  property p_standby_fall;
    $fell(standby_q) |-> reset_request_q || $past(reset_request_q);
  endproperty
  a_standby_fall: assert property (p_standby_fall) else $error("standby left without reset request");
  property p_rr_pulse;
    reset_request_q |=> !reset_request_q;
  endproperty
  a_rr_pulse: assert property (p_rr_pulse) else $error("reset request pulse too long");
  property p_sda_od;
    host_sda_out_q == 1'b0;
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("data pin driven high");

  c_hw: cover property (|hw_fault);
  c_rr: cover property (reset_request_q);
  c_ack: cover property (!host_sda_oe_n_q);
endmodule : error_status_reporting_monitor

bind error_status_reporting error_status_reporting_monitor i_mon (.ref_clk, .rst, .host_scl, .host_sda_in,
  .host_sda_out_q, .host_sda_oe_n_q, .hw_fault, .sw_fault, .processor_reset_done, .core_idle, .result_ready,
  .standby_q, .sensor_power_down_q, .host_irq_q, .reset_request_q);
`default_nettype wire

// ---- tb/host_port_model.sv ----
// Behavioural host master for the serial register port
`timescale 1ns/1ns
`default_nettype none
module host_port_model
  import err_report_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_drv_n
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  task automatic half();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask : half
  task automatic bit_io(input logic b, output logic r);
    sda_drv_n = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    sda_drv_n = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv_n = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_drv_n = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv_n = 1'b1;
    half();
  endtask : stop
  // Byte out, then ninth bit; m high releases the line
  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, a);
    if (m && a !== 1'b0) nacks++;
  endtask : byte_io
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({default_host_address, 1'b0}, 1'b1, q);
    byte_io(ra, 1'b1, q);
    byte_io(d, 1'b1, q);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] ra, output logic [7:0] d);
    logic [7:0] q;
    logic a;
    start();
    byte_io({default_host_address, 1'b0}, 1'b1, q);
    byte_io(ra, 1'b1, q);
    start();
    byte_io({default_host_address, 1'b1}, 1'b1, q);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    stop();
  endtask : rd
  // Two-byte read: master acknowledges the first byte, refuses the second
  task automatic rd2(input logic [7:0] ra, output logic [15:0] d);
    logic [7:0] q;
    logic a;
    start();
    byte_io({default_host_address, 1'b0}, 1'b1, q);
    byte_io(ra, 1'b1, q);
    start();
    byte_io({default_host_address, 1'b1}, 1'b1, q);
    for (int i = 15; i >= 8; i--) bit_io(1'b1, d[i]);
    bit_io(1'b0, a);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    stop();
  endtask : rd2
endmodule : host_port_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the error reporting block
`timescale 1ns/1ns
`default_nettype none
module tb
  import err_report_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic host_scl, host_sda_in, host_sda_out_q, host_sda_oe_n_q, drv_n;
  hw_fault_type hw_fault = '0;
  sw_fault_type sw_fault = '0;
  logic processor_reset_done = 1'b0;
  logic core_idle = 1'b0;
  logic [result_count-1:0] result_ready = '0;
  logic standby_q, sensor_power_down_q, host_irq_q, reset_request_q;
  logic [31:0] seed = 32'h27F6BB15;
  logic [7:0] v;
  logic [15:0] w;
  int n_resets = 0;
  int mismatches = 0;
  int n_checks = 0;
  int pos[8] = '{1, 0, 5, 6, 7, 2, 3, 4};
  logic [7:0] codes[8] = '{8'h80, 8'h30, 8'h21, 8'h22, 8'h24, 8'h11, 8'h12, 8'h14};

  always #4 ref_clk = ~ref_clk;
  // Reset request pulses seen on the output
  always @(posedge ref_clk) begin
    if (reset_request_q === 1'b1) n_resets++;
  end
  // Open drain data line with pull-up
  assign host_sda_in = drv_n & (host_sda_oe_n_q | host_sda_out_q);

  error_status_reporting i_error_status_reporting (.ref_clk, .rst, .host_scl, .host_sda_in, .host_sda_out_q,
    .host_sda_oe_n_q, .hw_fault, .sw_fault, .processor_reset_done, .core_idle, .result_ready, .standby_q,
    .sensor_power_down_q, .host_irq_q, .reset_request_q);
  host_port_model u_host (.ref_clk, .sda(host_sda_in), .scl(host_scl), .sda_drv_n(drv_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] sensor_exp(input logic [7:0] s);
    return {1'b0, s[6:4], 1'b0, s[2:0]};
  endfunction : sensor_exp
  function automatic logic [7:0] status_exp(input logic idle, input logic ee);
    return {4'h0, idle, ee, 2'b00};
  endfunction : status_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_host.rd(a, q);
    chk(q, exp);
  endtask : rd_chk
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    repeat (95000) @(posedge ref_clk);
    mismatches++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    results();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) tick();
    chk({4'h0, standby_q, sensor_power_down_q, host_irq_q, host_sda_oe_n_q}, 8'h01);
    rd_chk(event_flags_addr, zero_byte);
    rd_chk(8'h60, zero_byte);
    seed = lfsr(seed);
    tick();
    processor_reset_done = 1'b1;
    result_ready = seed[3:0];
    tick();
    processor_reset_done = 1'b0;
    result_ready = '0;
    repeat (3) tick();
    chk({7'h00, host_irq_q}, 8'h01);
    rd_chk(event_flags_addr, {2'b00, seed[3:0], 2'b01});
    rd_chk(event_flags_addr, zero_byte);
    repeat (3) tick();
    chk({7'h00, host_irq_q}, 8'h00);
    core_idle = 1'b1;
    repeat (3) tick();
    rd_chk(core_status_addr, status_exp(1'b1, 1'b0));
    for (int k = 0; k < 8; k++) begin
      tick();
      sw_fault = sw_fault_type'(14'h0001 << pos[k]);
      tick();
      sw_fault = '0;
      rd_chk(error_code_addr, codes[k]);
    end
    rd_chk(event_flags_addr, 8'h02);
    for (int k = 0; k < 3; k++) begin
      u_host.wr(reset_request_addr, reset_request_cmd);
      seed = lfsr(seed);
      v = (k == 0) ? 8'h77 : (seed[7:0] | 8'h01);
      tick();
      sw_fault.no_ack = v[2:0];
      sw_fault.identity_mismatch = v[6:4];
      tick();
      sw_fault = '0;
      rd_chk(sensor_fault_flags_addr, sensor_exp(v));
      rd_chk(event_flags_addr, 8'h03);
    end
    rd_chk(error_code_addr, code_none);
    for (int k = 0; k < 3; k++) begin
      u_host.wr(reset_request_addr, reset_request_cmd);
      rd_chk(event_flags_addr, 8'h01);
      seed = lfsr(seed);
      u_host.wr(mag_sample_rate_addr + 8'(k), seed[7:0]);
      rd_chk(mag_sample_rate_addr + 8'(k), seed[7:0]);
      core_idle = seed[8];
      tick();
      hw_fault = hw_fault_type'(3'h1 << k);
      tick();
      hw_fault = '0;
      repeat (2) tick();
      chk({5'h00, standby_q, sensor_power_down_q, host_irq_q}, 8'h07);
      for (int j = 0; j < 3; j++) rd_chk(mag_sample_rate_addr + 8'(j), zero_byte);
      rd_chk(core_status_addr, status_exp(seed[8], k == 2));
      rd_chk(event_flags_addr, 8'h02);
    end
    u_host.wr(reset_request_addr, reset_request_cmd);
    repeat (3) tick();
    chk({6'h00, standby_q, sensor_power_down_q}, 8'h00);
    rd_chk(core_status_addr, status_exp(core_idle, 1'b0));
    seed = lfsr(seed);
    u_host.wr(mag_sample_rate_addr, seed[7:0]);
    u_host.wr(accel_sample_rate_addr, seed[15:8]);
    u_host.rd2(mag_sample_rate_addr, w);
    chk(w[15:8], seed[7:0]);
    chk(w[7:0], seed[15:8]);
    chk(8'(n_resets), 8'h07);
    chk(8'(u_host.nacks), 8'h00);
    results();
  end
endmodule : tb
`default_nettype wire
